// >>> design/wtv_pkg.sv
// constants, types and helpers of the vbi data inserter
//
// Operation
// RULE1: wide screen word goes on video line 23 and no other line.
// RULE2: wide screen word is sent only in pal mode, suppressed otherwise.
// RULE3: fourteen payload bits follow a run-in sequence and a start code.
// RULE4: payload 0-7 from byte 2 bits 0-7, payload 8-13 from byte 1 bits 0-5.
// RULE5: word is sent only while the line enable bit of byte 0 is one; code tests the bit only when the word starts, not during it.
// RULE6: from 42.5 us after sync fall to line end, normal video is output.
// RULE7: software loads payload bit 3 as odd parity of payload bits 0-2.
// RULE8: software codes payload bits 4-13; bits 7, 12 and 13 reserved.
// RULE9: inserted teletext starts 10.2 us after the sync leading edge.
// RULE10: request has programmable edges; source answers after fixed delay.
// RULE11: window carries 360 bits when the request width field is zero.
// RULE12: insert enable zero keeps window closed, no request, no insertion.
// RULE13: sequencer on the system clock maps 37 bits onto 144 cycles.
// RULE14: group bits 10, 19, 28, 37 last three cycles, others four.
// RULE15: bits pass a phase interpolation filter before insertion.
// RULE16: every enabled teletext line is handled the same way.
// RULE17: serial input sampled once per sequencer bit, in order, window open.
// RULE18: payload leaves bit 0 first, right after the start code.
package wtv_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS   = 10000;
  localparam int INSERT_NS       = 10200;
  localparam int VIDEO_NS        = 42500;
  localparam int WSS_START_NS    = 11000;
  localparam int WSS_ELEM_NS     = 200;
  localparam int INSERT_CYC      = (INSERT_NS * 1000 + CLK_PERIOD_PS - 1)
                                   / CLK_PERIOD_PS;
  localparam int VIDEO_CYC       = (VIDEO_NS * 1000 + CLK_PERIOD_PS - 1)
                                   / CLK_PERIOD_PS;
  localparam int WSS_START_CYC   = (WSS_START_NS * 1000 + CLK_PERIOD_PS - 1)
                                   / CLK_PERIOD_PS;
  localparam int WSS_ELEM_CYC    = (WSS_ELEM_NS * 1000) / CLK_PERIOD_PS;
  localparam int INTERP_LAT      = 2;
  localparam int SEQ_START_CYC   = INSERT_CYC - INTERP_LAT - 1;

  // ----------------------------------------------------------------
  // wide screen word layout
  // ----------------------------------------------------------------
  localparam logic [9:0]  WSS_LINE     = 10'h017;
  localparam int          RUNIN_LEN    = 29;
  localparam int          START_LEN    = 24;
  localparam int          PAYLOAD_LEN  = 14;
  localparam int          ELEM_PER_BIT = 6;
  localparam int          WSS_ELEMS    = RUNIN_LEN + START_LEN
                                         + PAYLOAD_LEN * ELEM_PER_BIT;
  localparam logic [28:0] RUNIN_CODE   = 29'h1F1C71C7;
  localparam logic [23:0] START_CODE   = 24'h1E3C1F;
  localparam logic [5:0]  ELEM_ONE     = 6'h38;
  localparam logic [5:0]  ELEM_ZERO    = 6'h07;

  // ----------------------------------------------------------------
  // teletext protocol
  // ----------------------------------------------------------------
  localparam int         TEXT_BITS   = 360;
  localparam int         GROUP_BITS  = 37;
  localparam int         GROUP_CYC   = 144;
  localparam logic [2:0] LONG_CYC    = 3'h4;
  localparam logic [2:0] SHORT_CYC   = 3'h3;
  localparam logic [8:0] WIDTH_STEP  = 9'h008;
  localparam logic [9:0] TEXT_FIRST_LINE = 10'h007;
  localparam int         TEXT_LINES  = 16;

  // ----------------------------------------------------------------
  // register map (byte wide, 4-bit address)
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_SIG0    = 4'h1;
  localparam logic [3:0] REG_SIG1    = 4'h2;
  localparam logic [3:0] REG_SIG2    = 4'h3;
  localparam logic [3:0] REG_REQ_LEAD = 4'h4;
  localparam logic [3:0] REG_REQ_TAIL = 4'h5;
  localparam logic [3:0] REG_TEXT_CTL = 4'h6;
  localparam logic [3:0] REG_LINES_LO = 4'h7;
  localparam logic [3:0] REG_LINES_HI = 4'h8;
  localparam logic [3:0] REG_STATUS  = 4'h9;
  localparam int CTRL_PAL_BIT       = 0;
  localparam int CTRL_TEXT_EN_BIT   = 1;
  localparam int SIG0_LINE_EN_BIT   = 7;
  localparam int STAT_WSS_BIT       = 0;
  localparam int STAT_TEXT_BIT      = 1;
  localparam int STAT_REQ_BIT       = 2;
  localparam int STAT_VIDEO_BIT     = 3;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // types and helpers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_REQ  = 3'b010,
    TX_RUN  = 3'b100
  } wtv_text_state_t;

  // short bits of a group: 10, 19, 28 and 37 counted from one
  function automatic logic [2:0] bit_len(input logic [5:0] idx);
    bit_len = (idx == 6'h09 || idx == 6'h12 || idx == 6'h1B ||
               idx == 6'h24) ? SHORT_CYC : LONG_CYC;
  endfunction

  // cycles taken by n bits
  function automatic logic [11:0] span_cyc(input logic [8:0] n);
    logic [5:0]  g;
    logic [11:0] c;
    g = 6'h00;
    c = 12'h000;
    for (int i = 0; i < TEXT_BITS; i++)
    begin
      if (i < int'(n))
      begin
        c = c + 12'(bit_len(g));
        g = (g == 6'(GROUP_BITS - 1)) ? 6'h00 : g + 6'h01;
      end
    end
    span_cyc = c;
  endfunction

endpackage

// >>> design/wtv_seq_if.sv
// link between the top block and the teletext sequencer
`timescale 1ns/100ps
interface wtv_seq_if;
  logic       start;
  logic [8:0] limit;
  logic       busy;
  logic       sample;
  logic [1:0] phase;
  logic [2:0] len;
  logic       done;

  modport seq (
    input  start,
    input  limit,
    output busy,
    output sample,
    output phase,
    output len,
    output done
  );
  modport ctl (
    output start,
    output limit,
    input  busy,
    input  sample,
    input  phase,
    input  len,
    input  done
  );
endinterface

// >>> design/wtv_text_seq.sv
// teletext bit sequencer: 37 bits in 144 clocks
`timescale 1ns/100ps
module wtv_text_seq (
  input  wire logic CLK,
  input  wire logic RST,
  wtv_seq_if.seq    sq
);

  logic [2:0] ph_q;
  logic [5:0] grp_q;
  logic [8:0] cnt_q;
  logic       busy_q;
  logic       done_q;
  logic [2:0] len;
  logic       bit_end;

  assign len     = wtv_pkg::bit_len(grp_q); // RULE14
  assign bit_end = busy_q && (ph_q == len - 3'h1);

  // ----------------------------------------------------------------
  // bit timing
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      busy_q <= 1'b0;
      ph_q   <= 3'h0;
      grp_q  <= 6'h00;
      cnt_q  <= 9'h000;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (sq.start && !busy_q)
      begin
        busy_q <= (sq.limit != 9'h000);
        ph_q   <= 3'h0;
        grp_q  <= 6'h00;
        cnt_q  <= 9'h000;
      end
      else if (busy_q)
      begin
        ph_q <= bit_end ? 3'h0 : ph_q + 3'h1;
        if (bit_end)
        begin
          grp_q <= (grp_q == 6'(wtv_pkg::GROUP_BITS - 1)) ? 6'h00
                   : grp_q + 6'h01; // RULE13
          cnt_q <= cnt_q + 9'h001;
          if (cnt_q == sq.limit - 9'h001)
          begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
      end
    end
  end

  // sample in the middle of each bit
  assign sq.sample = busy_q && (ph_q == 3'h1); // RULE17
  assign sq.busy   = busy_q;
  assign sq.phase  = ph_q[1:0];
  assign sq.len    = len;
  assign sq.done   = done_q;

endmodule // wtv_text_seq

// >>> design/wtv_interp.sv
// phase interpolation filter for the teletext bit stream
`timescale 1ns/100ps
module wtv_interp #(
  parameter logic [7:0] HIGH_LEVEL = 8'hC0
) (
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       load,
  input  wire logic       bit_in,
  input  wire logic       run,
  input  wire logic [1:0] phase,
  input  wire logic [2:0] len,
  output logic      [7:0] level,
  output logic            valid
);

  logic       cur_q;
  logic       prev_q;
  logic [9:0] mix_q;
  logic       v_q;
  logic [7:0] lvl_q;
  logic       val_q;

  // weighted blend of previous and current bit over the bit period
  function automatic logic [9:0] blend(input logic p, input logic c,
                                       input logic [1:0] ph,
                                       input logic [2:0] ln);
    logic [9:0] w;
    w = {8'h00, ph} + 10'h001;
    if (w > {7'h00, ln})
      w = {7'h00, ln};
    blend = (c ? (w * {2'h0, HIGH_LEVEL}) / {7'h00, ln} : 10'h000) +
            (p ? (({7'h00, ln} - w) * {2'h0, HIGH_LEVEL}) / {7'h00, ln}
               : 10'h000);
  endfunction

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      cur_q  <= 1'b0;
      prev_q <= 1'b0;
      mix_q  <= 10'h000;
      v_q    <= 1'b0;
      lvl_q  <= 8'h00;
      val_q  <= 1'b0;
    end
    else
    begin
      if (load)
      begin
        prev_q <= cur_q;
        cur_q  <= bit_in;
      end
      mix_q <= run ? blend(prev_q, cur_q, phase, len) : 10'h000; // RULE15
      v_q   <= run;
      lvl_q <= mix_q[7:0];
      val_q <= v_q;
    end
  end

  assign level = lvl_q;
  assign valid = val_q;

endmodule // wtv_interp

// >>> design/wtv_inserter.sv
// vbi data inserter: wide screen word and teletext insertion
`timescale 1ns/100ps
module wtv_inserter (
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       HSYNC_FALL,
  input  wire logic [9:0] LINE_NUMBER,
  input  wire logic       TEXT_SERIAL_IN,
  output logic            TEXT_REQUEST_OUT,
  output logic            WSS_ACTIVE,
  output logic            WSS_LEVEL,
  output logic            TEXT_ACTIVE,
  output logic      [7:0] TEXT_LEVEL,
  output logic            VIDEO_PASS
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_q;
  logic [7:0]  sig0_q;
  logic [7:0]  sig1_q;
  logic [7:0]  sig2_q;
  logic [7:0]  req_lead_q;
  logic [7:0]  req_tail_q;
  logic [7:0]  text_ctl_q;
  logic [15:0] lines_q;
  logic [7:0]  rdata_q;
  logic [7:0]  status;

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ctrl_q     <= wtv_pkg::RESET_BYTE;
      sig0_q     <= wtv_pkg::RESET_BYTE;
      sig1_q     <= wtv_pkg::RESET_BYTE;
      sig2_q     <= wtv_pkg::RESET_BYTE;
      req_lead_q <= wtv_pkg::RESET_BYTE;
      req_tail_q <= wtv_pkg::RESET_BYTE;
      text_ctl_q <= wtv_pkg::RESET_BYTE;
      lines_q    <= {wtv_pkg::RESET_BYTE, wtv_pkg::RESET_BYTE};
    end
    else if (WR)
    begin
      unique case (ADDR)
        wtv_pkg::REG_CTRL:     ctrl_q        <= WDATA;
        wtv_pkg::REG_SIG0:     sig0_q        <= WDATA;
        wtv_pkg::REG_SIG1:     sig1_q        <= WDATA;
        wtv_pkg::REG_SIG2:     sig2_q        <= WDATA;
        wtv_pkg::REG_REQ_LEAD: req_lead_q    <= WDATA;
        wtv_pkg::REG_REQ_TAIL: req_tail_q    <= WDATA;
        wtv_pkg::REG_TEXT_CTL: text_ctl_q    <= WDATA;
        wtv_pkg::REG_LINES_LO: lines_q[7:0]  <= WDATA;
        wtv_pkg::REG_LINES_HI: lines_q[15:8] <= WDATA;
        default:               ;
      endcase
    end
  end

  // read data stand in the cycle after the read strobe only
  always_ff @(posedge CLK)
  begin
    if (RST)
      rdata_q <= 8'h00;
    else if (RD)
    begin
      unique case (ADDR)
        wtv_pkg::REG_CTRL:     rdata_q <= ctrl_q;
        wtv_pkg::REG_SIG0:     rdata_q <= sig0_q;
        wtv_pkg::REG_SIG1:     rdata_q <= sig1_q;
        wtv_pkg::REG_SIG2:     rdata_q <= sig2_q;
        wtv_pkg::REG_REQ_LEAD: rdata_q <= req_lead_q;
        wtv_pkg::REG_REQ_TAIL: rdata_q <= req_tail_q;
        wtv_pkg::REG_TEXT_CTL: rdata_q <= text_ctl_q;
        wtv_pkg::REG_LINES_LO: rdata_q <= lines_q[7:0];
        wtv_pkg::REG_LINES_HI: rdata_q <= lines_q[15:8];
        wtv_pkg::REG_STATUS:   rdata_q <= status;
        default:               rdata_q <= 8'h00;
      endcase
    end
    else
      rdata_q <= 8'h00;
  end

  assign RDATA = rdata_q;

  // ----------------------------------------------------------------
  // line position
  // ----------------------------------------------------------------
  logic [15:0] pos_q;
  logic        pal;
  logic        text_en;

  assign pal     = ctrl_q[wtv_pkg::CTRL_PAL_BIT];
  assign text_en = ctrl_q[wtv_pkg::CTRL_TEXT_EN_BIT];

  always_ff @(posedge CLK)
  begin
    if (RST)
      pos_q <= 16'h0000;
    else if (HSYNC_FALL)
      pos_q <= 16'h0000;
    else if (pos_q != 16'hFFFF)
      pos_q <= pos_q + 16'h0001;
  end

  // ----------------------------------------------------------------
  // wide screen signalling
  // ----------------------------------------------------------------
  logic [wtv_pkg::WSS_ELEMS-1:0] wss_sh_q;
  logic [7:0]                    elem_cnt_q;
  logic [7:0]                    elem_div_q;
  logic                          wss_busy_q;
  logic                          wss_go;
  logic [13:0]                   payload;
  logic                          line23;

  // build the element train, payload bit 0 first
  function automatic logic [wtv_pkg::PAYLOAD_LEN*6-1:0] biphase(
    input logic [13:0] p);
    logic [wtv_pkg::PAYLOAD_LEN*6-1:0] r;
    r = '0;
    for (int i = 0; i < wtv_pkg::PAYLOAD_LEN; i++)
      r[(wtv_pkg::PAYLOAD_LEN-1-i)*6 +: 6] =
        p[i] ? wtv_pkg::ELEM_ONE : wtv_pkg::ELEM_ZERO; // RULE18
    biphase = r;
  endfunction

  assign payload = {sig1_q[5:0], sig2_q}; // RULE4
  assign line23  = (LINE_NUMBER == wtv_pkg::WSS_LINE); // RULE1
  assign wss_go  = line23 && pal // RULE2
                   && sig0_q[wtv_pkg::SIG0_LINE_EN_BIT] // RULE5
                   && (pos_q == 16'(wtv_pkg::WSS_START_CYC - 1));

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      wss_sh_q   <= '0;
      elem_cnt_q <= 8'h00;
      elem_div_q <= 8'h00;
      wss_busy_q <= 1'b0;
    end
    else if (wss_go && !wss_busy_q)
    begin
      wss_sh_q   <= {wtv_pkg::RUNIN_CODE, wtv_pkg::START_CODE,
                     biphase(payload)}; // RULE3
      elem_cnt_q <= 8'h00;
      elem_div_q <= 8'h00;
      wss_busy_q <= 1'b1;
    end
    else if (wss_busy_q)
    begin
      if (!pal || !line23)
        wss_busy_q <= 1'b0;
      else if (elem_div_q == 8'(wtv_pkg::WSS_ELEM_CYC - 1))
      begin
        elem_div_q <= 8'h00;
        wss_sh_q   <= {wss_sh_q[wtv_pkg::WSS_ELEMS-2:0], 1'b0};
        elem_cnt_q <= elem_cnt_q + 8'h01;
        if (elem_cnt_q == 8'(wtv_pkg::WSS_ELEMS - 1))
          wss_busy_q <= 1'b0;
      end
      else
        elem_div_q <= elem_div_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // video pass region of line 23
  // ----------------------------------------------------------------
  logic late_q;

  always_ff @(posedge CLK)
  begin
    if (RST)
      late_q <= 1'b0;
    else if (HSYNC_FALL)
      late_q <= 1'b0;
    else if (pos_q == 16'(wtv_pkg::VIDEO_CYC - 1))
      late_q <= 1'b1; // RULE6
  end

  // ----------------------------------------------------------------
  // teletext window and request
  // ----------------------------------------------------------------
  wtv_pkg::wtv_text_state_t st_q;
  wtv_seq_if                sq ();
  logic        text_line;
  logic [9:0]  line_off;
  logic [8:0]  limit;
  logic [15:0] req_rise;
  logic [15:0] req_fall;
  logic        req_q;
  logic        seq_go;

  assign line_off  = LINE_NUMBER - wtv_pkg::TEXT_FIRST_LINE;
  assign text_line = text_en // RULE12
                     && (LINE_NUMBER >= wtv_pkg::TEXT_FIRST_LINE)
                     && (line_off < 10'(wtv_pkg::TEXT_LINES))
                     && lines_q[line_off[3:0]]; // RULE16
  // width field zero gives the full 360 bit window
  assign limit    = 9'(wtv_pkg::TEXT_BITS)
                    - {1'b0, text_ctl_q[3:0], 4'h0} / 9'h002; // RULE11
  assign req_rise = 16'(wtv_pkg::SEQ_START_CYC) - {8'h00, req_lead_q};
  assign req_fall = 16'(wtv_pkg::SEQ_START_CYC)
                    + {4'h0, wtv_pkg::span_cyc(limit)}
                    - {8'h00, req_tail_q}; // RULE10
  assign seq_go   = text_line && (pos_q == 16'(wtv_pkg::SEQ_START_CYC))
                    && (st_q == wtv_pkg::TX_REQ || (req_lead_q == 8'h00
                    && st_q == wtv_pkg::TX_IDLE)); // RULE9

  always_ff @(posedge CLK)
  begin
    if (RST)
      st_q <= wtv_pkg::TX_IDLE;
    else if (!text_line)
      st_q <= wtv_pkg::TX_IDLE;
    else
    begin
      unique case (st_q)
        wtv_pkg::TX_IDLE:
          if (seq_go)
            st_q <= wtv_pkg::TX_RUN;
          else if (pos_q == req_rise)
            st_q <= wtv_pkg::TX_REQ;
        wtv_pkg::TX_REQ:
          if (seq_go)
            st_q <= wtv_pkg::TX_RUN;
        wtv_pkg::TX_RUN:
          if (sq.done || HSYNC_FALL)
            st_q <= wtv_pkg::TX_IDLE;
        default:
          st_q <= wtv_pkg::TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      req_q <= 1'b0;
    else if (!text_line || HSYNC_FALL)
      req_q <= 1'b0; // RULE12
    else if (pos_q == req_fall)
      req_q <= 1'b0;
    else if (pos_q == req_rise)
      req_q <= 1'b1; // RULE10
  end

  assign sq.start = seq_go;
  assign sq.limit = limit;

  wtv_text_seq u_seq (
    .CLK (CLK),
    .RST (RST),
    .sq  (sq.seq)
  );

  wtv_interp u_interp (
    .CLK    (CLK),
    .RST    (RST),
    .load   (sq.sample), // RULE17
    .bit_in (TEXT_SERIAL_IN),
    .run    (sq.busy && text_line),
    .phase  (sq.phase),
    .len    (sq.len),
    .level  (TEXT_LEVEL),
    .valid  (TEXT_ACTIVE)
  );

  // ----------------------------------------------------------------
  // outputs and status
  // ----------------------------------------------------------------
  assign TEXT_REQUEST_OUT = req_q;
  assign WSS_ACTIVE       = wss_busy_q && !late_q;
  assign WSS_LEVEL        = wss_busy_q && !late_q
                            && wss_sh_q[wtv_pkg::WSS_ELEMS-1];
  assign VIDEO_PASS       = line23 && late_q && !HSYNC_FALL; // RULE6

  always_comb
  begin
    status = 8'h00;
    status[wtv_pkg::STAT_WSS_BIT]   = wss_busy_q;
    status[wtv_pkg::STAT_TEXT_BIT]  = sq.busy;
    status[wtv_pkg::STAT_REQ_BIT]   = req_q;
    status[wtv_pkg::STAT_VIDEO_BIT] = late_q;
  end

endmodule // wtv_inserter

// >>> test/wtv_text_source.sv
// teletext source model answering the request after a pipeline delay
`timescale 1ns/100ps
module wtv_text_source #(
  parameter int DELAY = 8
) (
  input  wire logic CLK,
  input  wire logic req,
  input  wire logic data_bit,
  output logic      ser
);
  logic [DELAY-1:0] pipe_q = '0;
  logic             ser_q  = 1'b0;
  // ----------------------------------------------------------------
  // fixed pipeline from request to data, toggling when not gated
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    pipe_q <= {pipe_q[DELAY-2:0], req};
    ser_q  <= pipe_q[DELAY-1] ? data_bit : ~ser_q;
  end
  assign ser = ser_q;
endmodule  // wtv_text_source

// >>> test/wtv_inserter_monitor.sv
// assertion checker for the vbi data inserter ports
`timescale 1ns/100ps
module wtv_inserter_monitor (
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       HSYNC_FALL,
  input wire logic [9:0] LINE_NUMBER,
  input wire logic       TEXT_REQUEST_OUT,
  input wire logic       WSS_ACTIVE,
  input wire logic       WSS_LEVEL,
  input wire logic       TEXT_ACTIVE,
  input wire logic       VIDEO_PASS
);
  logic [12:0] pos_q;
  logic [7:0]  lead_q;
  logic        pal_q;
  logic        ten_q;
  logic        len_q;
  // ----------------------------------------------------------------
  // shadow of line position and control bits
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    pos_q <= (RST || HSYNC_FALL) ? 13'h0000 : pos_q + 13'h0001;
  end
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      {pal_q, ten_q, len_q, lead_q} <= 11'h000;
    end
    else if (WR)
    begin
      if (ADDR == wtv_pkg::REG_CTRL)
        {ten_q, pal_q} <= WDATA[1:0];
      if (ADDR == wtv_pkg::REG_SIG0)
        len_q <= WDATA[7];
      if (ADDR == wtv_pkg::REG_REQ_LEAD)
        lead_q <= WDATA;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_wss_line;
    WSS_ACTIVE |-> LINE_NUMBER == 10'h017;
  endproperty
  a_wss_line: assert property (p_wss_line)
    else $error("wide screen word off line 23");
  property p_wss_pal;
    !pal_q [*2] |-> !WSS_ACTIVE;
  endproperty
  a_wss_pal: assert property (p_wss_pal)
    else $error("wide screen word outside pal");
  property p_wss_first;
    $rose(WSS_ACTIVE) |-> WSS_LEVEL == wtv_pkg::RUNIN_CODE[28];
  endproperty
  a_wss_first: assert property (p_wss_first)
    else $error("wide screen word does not open with run-in");
  property p_wss_enable;
    !len_q [*2] |-> !WSS_ACTIVE;
  endproperty
  a_wss_enable: assert property (p_wss_enable)
    else $error("wide screen word with line enable clear");
  property p_video_pass;
    VIDEO_PASS |-> !WSS_ACTIVE && LINE_NUMBER == 10'h017;
  endproperty
  a_video_pass: assert property (p_video_pass)
    else $error("video region overlaps wide screen word");
  property p_video_time;
    $rose(VIDEO_PASS) |-> pos_q inside {[13'h1099:13'h109C]};
  endproperty
  a_video_time: assert property (p_video_time)
    else $error("video region starts at wrong position");
  property p_text_off;
    !ten_q [*8] |-> !TEXT_REQUEST_OUT && !TEXT_ACTIVE;
  endproperty
  a_text_off: assert property (p_text_off)
    else $error("teletext activity while disabled");
  property p_req_rise;
    $rose(TEXT_REQUEST_OUT) |->
      pos_q + {5'h00, lead_q} inside {[13'h03F8:13'h03FA]};
  endproperty
  a_req_rise: assert property (p_req_rise)
    else $error("request edge not at programmed lead");
  property p_text_start;
    $rose(TEXT_ACTIVE) |-> pos_q inside {[13'h03FB:13'h03FE]};
  endproperty
  a_text_start: assert property (p_text_start)
    else $error("teletext not inserted at fixed offset");
endmodule  // wtv_inserter_monitor

bind wtv_inserter wtv_inserter_monitor u_mon (
  .CLK              (CLK),
  .RST              (RST),
  .ADDR             (ADDR),
  .WDATA            (WDATA),
  .WR               (WR),
  .HSYNC_FALL       (HSYNC_FALL),
  .LINE_NUMBER      (LINE_NUMBER),
  .TEXT_REQUEST_OUT (TEXT_REQUEST_OUT),
  .WSS_ACTIVE       (WSS_ACTIVE),
  .WSS_LEVEL        (WSS_LEVEL),
  .TEXT_ACTIVE      (TEXT_ACTIVE),
  .VIDEO_PASS       (VIDEO_PASS)
);

// >>> test/wtv_inserter_tb_top.sv
// testbench of the vbi data inserter
`timescale 1ns/100ps
module wtv_inserter_tb_top;
  logic        CLK = 1'b0;
  logic        RST = 1'b1;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic        HSYNC_FALL = 1'b0;
  logic [3:0]  ADDR = 4'h0;
  logic [7:0]  WDATA = 8'h00;
  logic [9:0]  LINE_NUMBER = 10'h000;
  logic        src_bit = 1'b0;
  logic        rd_seen = 1'b0;
  logic        ser, req, wss_act, wss_lvl, txt_act, vpass;
  logic [7:0]  RDATA, txt_lvl;
  logic [7:0]  rd_q[$];
  logic        wss_q[$];
  logic [19:0] txt_q[$];
  logic [13:0] pay;
  int          n_fail = 0;
  int          check_count = 0;

  always #5 CLK = ~CLK;

  wtv_inserter dut (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .HSYNC_FALL(HSYNC_FALL),
    .LINE_NUMBER(LINE_NUMBER), .TEXT_SERIAL_IN(ser),
    .TEXT_REQUEST_OUT(req), .WSS_ACTIVE(wss_act), .WSS_LEVEL(wss_lvl),
    .TEXT_ACTIVE(txt_act), .TEXT_LEVEL(txt_lvl), .VIDEO_PASS(vpass));
  wtv_text_source #(.DELAY(8)) src (.CLK(CLK), .req(req),
    .data_bit(src_bit), .ser(ser));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    RD    <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    ADDR <= a;
    RD   <= 1'b1;
    WR   <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic line(input logic [9:0] n);
    WR          <= 1'b0;
    RD          <= 1'b0;
    HSYNC_FALL  <= 1'b1;
    LINE_NUMBER <= n;
    @(posedge CLK);
    HSYNC_FALL <= 1'b0;
    repeat (4400) @(posedge CLK);
  endtask
  task automatic exp_wss(input logic [13:0] p);
    logic [5:0] el;
    for (int e = 0; e < wtv_pkg::WSS_ELEMS; e++)
    begin
      el = p[(e - 53) / 6] ? wtv_pkg::ELEM_ONE : wtv_pkg::ELEM_ZERO;
      if (e < 29)
        wss_q.push_back(wtv_pkg::RUNIN_CODE[28 - e]);
      else if (e < 53)
        wss_q.push_back(wtv_pkg::START_CODE[52 - e]);
      else
        wss_q.push_back(el[5 - (e - 53) % 6]);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // output watchers
  // ----------------------------------------------------------------
  always @(posedge CLK)
  begin
    if (rd_seen)
      check({12'h000, RDATA}, {12'h000, rd_q.pop_front()});
    rd_seen <= RD;
  end
  initial
  begin : wss_mon
    forever
    begin
      @(posedge CLK);
      if (wss_act === 1'b1)
      begin
        check(20'(wss_q.size()), 20'h00089);
        repeat (9) @(posedge CLK);
        for (int e = 0; e < 137 && wss_q.size() > 0; e++)
        begin
          check({19'h0, wss_lvl}, {19'h0, wss_q.pop_front()});
          repeat (20) @(posedge CLK);
        end
      end
    end
  end
  initial
  begin : txt_mon
    logic [19:0] n;
    logic [7:0]  lv;
    forever
    begin
      @(posedge CLK);
      n  = 20'h00000;
      lv = 8'h00;
      while (txt_act === 1'b1 && n < 20'h00BB8)
      begin
        n++;
        if (n == 20'h002BC)
          lv = txt_lvl;
        @(posedge CLK);
      end
      if (n != 20'h00000)
      begin
        if (txt_q.size() == 0)
          check(n, 20'h00000);
        else
          check({n[11:0], lv}, txt_q.pop_front());
      end
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [11:0] lens [2];
    lens = '{12'h57A, 12'h55A};
    void'($urandom(32'hACA6));
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    rd(wtv_pkg::REG_CTRL, 8'h00);
    wr(4'hA, 8'hFF);
    rd(4'hA, 8'h00);
    wr(wtv_pkg::REG_STATUS, 8'hFF);
    rd(wtv_pkg::REG_STATUS, 8'h00);
    pay = 14'($urandom);
    pay = pay & 14'h0F7F;
    pay[3] = ~^pay[2:0];
    wr(wtv_pkg::REG_CTRL, 8'h01);
    wr(wtv_pkg::REG_SIG0, 8'h80);
    wr(wtv_pkg::REG_SIG1, {2'h0, pay[13:8]});
    wr(wtv_pkg::REG_SIG2, pay[7:0]);
    rd(wtv_pkg::REG_SIG2, pay[7:0]);
    exp_wss(pay);
    line(10'h017);
    line(10'h016);
    wr(wtv_pkg::REG_CTRL, 8'h00);
    line(10'h017);
    wr(wtv_pkg::REG_CTRL, 8'h01);
    wr(wtv_pkg::REG_SIG0, 8'h00);
    line(10'h017);
    wr(wtv_pkg::REG_REQ_LEAD, 8'h14);
    wr(wtv_pkg::REG_LINES_LO, 8'hFF);
    wr(wtv_pkg::REG_LINES_HI, 8'hFF);
    wr(wtv_pkg::REG_CTRL, 8'h02);
    for (int k = 0; k < 2; k++)
    begin
      src_bit <= k[0];
      wr(wtv_pkg::REG_TEXT_CTL, 8'(k));
      txt_q.push_back({lens[k], k[0] ? 8'hC0 : 8'h00});
      line(10'h00A + 10'(k * 5));
    end
    wr(wtv_pkg::REG_CTRL, 8'h00);
    line(10'h00A);
    check(20'(rd_q.size() + wss_q.size() + txt_q.size()), 20'h00000);
    final_report();
  end
endmodule  // wtv_inserter_tb_top
